/* core/lp_dac_consts.vh */
`ifndef LP_DAC_CONSTS_VH
`define LP_DAC_CONSTS_VH

// register byte addresses on the avalon port
`define ADDR_W              16
`define ADDR_REF_CTL        16'h2050
`define ADDR_DAC_DATA       16'h2120
`define ADDR_DAC_SW         16'h2124
`define ADDR_DAC_CFG        16'h2128
`define ADDR_CM_SEL         16'h235c

// reset values
`define RST_REF_CTL         32'h0000_0000
`define RST_DAC_DATA        32'h0000_0000
`define RST_DAC_SW          32'h0000_0008
`define RST_DAC_CFG         32'h0000_0002
`define RST_CM_SEL          32'h0000_0000

// writable bits of each register, reserved read-only bits are zero here
`define WM_REF_CTL          32'h0000_0003
`define WM_DAC_DATA         32'h0003_ffff
`define WM_DAC_SW           32'h0000_003f
`define WM_DAC_CFG          32'h0000_007f
`define WM_CM_SEL           32'h0000_000f

// switch control field positions
`define SW_OVERRIDE_BIT     5
`define SW_FIELD_HI         4
`define SW_FIELD_LO         0
`define SW_BIAS_POT_BIT     4
`define SW_BIAS_FILT_BIT    3
`define SW_ZERO_LPTIA_BIT   2
`define SW_ZERO_FILT_BIT    1
`define SW_ZERO_HSTIA_BIT   0

// data field positions
`define COARSE_HI           17
`define COARSE_LO           12
`define FINE_HI             11
`define FINE_LO             0

// reference control positions
`define REF_BUF_PD_BIT      1
`define BANDGAP_PD_BIT      0

// common-mode select position
`define CM_ENABLE_BIT       3

// configuration register positions
`define CFG_WAVE_BIT        6
`define CFG_DIAG_BIT        5
`define CFG_ZERO_MUX_BIT    4
`define CFG_BIAS_MUX_BIT    3
`define CFG_REF_SEL_BIT     2
`define CFG_PD_BIT          1
`define CFG_WEN_BIT         0

// switch patterns used while the override is off; all-open also under power-down
`define SW_W                5
`define SW_PATTERN_NORMAL   5'h0a
`define SW_PATTERN_DIAG     5'h0b
`define SW_ALL_OPEN         5'h00

// avalon response codes
`define RESP_OKAY           2'h0
`define RESP_DECODE_ERR     2'h3

`endif

/* core/reg_field.v */
`timescale 1ns/1ps

// one 32-bit software register with per-bit write mask, byte lanes and a hold-clear
module reg_field #(
  parameter [31:0] RESET_VALUE = 32'h0000_0000,
  parameter [31:0] WRITE_MASK  = 32'hffff_ffff
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        clear,
  input  wire        write_en,
  input  wire [31:0] write_data,
  input  wire [3:0]  byte_en,
  output reg  [31:0] value
);

  wire [31:0] lane_mask;
  wire [31:0] bit_mask;

  // byte enables widen to bit lanes, then only documented writable bits pass
  assign lane_mask = {{8{byte_en[3]}}, {8{byte_en[2]}}, {8{byte_en[1]}}, {8{byte_en[0]}}};
  assign bit_mask  = lane_mask & WRITE_MASK;

  // clear wins over write so a blocked register can never pick up data
  always @(posedge clk)
  begin
    if (rst)
      value <= RESET_VALUE;
    else if (clear)
      value <= 32'h0000_0000;
    else if (write_en)
      value <= (value & ~bit_mask) | (write_data & bit_mask);
  end

endmodule // reg_field

/* core/lp_dac_switch_and_ref_regs.v */
`timescale 1ns/1ps
`include "lp_dac_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module lp_dac_switch_and_ref_regs (
  input  wire                 clk,
  input  wire                 rst,
  input  wire [`ADDR_W-1:0]   address,
  input  wire                 read,
  input  wire                 write,
  input  wire [31:0]          writedata,
  input  wire [3:0]           byteenable,
  output reg  [31:0]          readdata,
  output reg  [1:0]           response,
  output reg                  waitrequest,
  output reg                  bias_to_potentiostat_switch,
  output reg                  bias_to_filter_pin_switch,
  output reg                  zero_to_lowpower_tia_switch,
  output reg                  zero_to_filter_pin_switch,
  output reg                  zero_to_highspeed_tia_switch,
  output wire [5:0]           coarse_code,
  output wire [11:0]          fine_code,
  output reg                  ref_buffer_powerdown,
  output reg                  bandgap_powerdown,
  output reg                  common_mode_enable,
  output reg                  dac_powerdown,
  output reg                  waveform_source,
  output reg                  zero_mux_select,
  output reg                  bias_mux_select,
  output reg                  reference_select
);

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake state

  // one-hot states; ST_ANSWER is the only cycle with waitrequest low
  localparam [1:0] ST_IDLE   = 2'b01;
  localparam [1:0] ST_ANSWER = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  wire        request;
  wire        commit;
  wire        hit_ref;
  wire        hit_data;
  wire        hit_sw;
  wire        hit_cfg;
  wire        hit_cm;
  wire        hit_any;

  assign request = read | write;
  // a write lands only at the edge where waitrequest is seen low
  assign commit  = write & ~waitrequest & (state == ST_ANSWER);

  // address decode, full byte address compare
  // a partial decode would alias reserved space onto live registers
  assign hit_ref  = (address == `ADDR_REF_CTL);
  assign hit_data = (address == `ADDR_DAC_DATA);
  assign hit_sw   = (address == `ADDR_DAC_SW);
  assign hit_cfg  = (address == `ADDR_DAC_CFG);
  assign hit_cm   = (address == `ADDR_CM_SEL);
  assign hit_any  = hit_ref | hit_data | hit_sw | hit_cfg | hit_cm;

  // per-register commit strobes; each lives only in the answer cycle, so a request
  // still held after its answer edge is taken again from idle and writes once more
  wire        commit_ref;
  wire        commit_data;
  wire        commit_sw;
  wire        commit_cfg;
  wire        commit_cm;

  assign commit_ref  = commit & hit_ref;
  assign commit_data = commit & hit_data;
  assign commit_sw   = commit & hit_sw;
  assign commit_cfg  = commit & hit_cfg;
  assign commit_cm   = commit & hit_cm;

  // a request seen while answering is not taken again; the master drops it
  // right after the answer edge and may raise the next one straight away
  // two-state handshake: one wait cycle, then one answer cycle
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (request)
          next_state = ST_ANSWER;
      end
      ST_ANSWER:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // handshake state register
  always @(posedge clk)
  begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register storage

  wire [31:0] ref_ctl;
  wire [31:0] dac_data;
  wire [31:0] dac_sw;
  wire [31:0] dac_cfg;
  wire [31:0] cm_sel;
  wire        data_write_enable;
  wire        data_clear;

  // limitation: clearing the write enable loses the codes, since the data
  // register is held clear rather than merely write-protected
  assign data_write_enable = dac_cfg[`CFG_WEN_BIT];
  // data is held at zero whenever writes to it are disabled
  assign data_clear        = ~data_write_enable;

  // reserved read-only bits are outside every write mask
  // byte lanes are honoured, so a partial write leaves other lanes alone
  reg_field #(
    .RESET_VALUE (`RST_REF_CTL),
    .WRITE_MASK  (`WM_REF_CTL)
  ) u_ref_ctl (
    .clk        (clk),
    .rst        (rst),
    .clear      (1'b0),
    .write_en   (commit_ref),
    .write_data (writedata),
    .byte_en    (byteenable),
    .value      (ref_ctl)
  );

  reg_field #(
    .RESET_VALUE (`RST_DAC_DATA),
    .WRITE_MASK  (`WM_DAC_DATA)
  ) u_dac_data (
    .clk        (clk),
    .rst        (rst),
    .clear      (data_clear),
    .write_en   (commit_data & data_write_enable),
    .write_data (writedata),
    .byte_en    (byteenable),
    .value      (dac_data)
  );

  // switch register bit 3 resets to 1, the rest to 0; override is off, so bit 3 closes no switch
  reg_field #(
    .RESET_VALUE (`RST_DAC_SW),
    .WRITE_MASK  (`WM_DAC_SW)
  ) u_dac_sw (
    .clk        (clk),
    .rst        (rst),
    .clear      (1'b0),
    .write_en   (commit_sw),
    .write_data (writedata),
    .byte_en    (byteenable),
    .value      (dac_sw)
  );

  // configuration starts powered down with data writes disabled
  reg_field #(
    .RESET_VALUE (`RST_DAC_CFG),
    .WRITE_MASK  (`WM_DAC_CFG)
  ) u_dac_cfg (
    .clk        (clk),
    .rst        (rst),
    .clear      (1'b0),
    .write_en   (commit_cfg),
    .write_data (writedata),
    .byte_en    (byteenable),
    .value      (dac_cfg)
  );

  // low three bits here are reserved but stay read/write
  // so software may park values there; they reach no output
  reg_field #(
    .RESET_VALUE (`RST_CM_SEL),
    .WRITE_MASK  (`WM_CM_SEL)
  ) u_cm_sel (
    .clk        (clk),
    .rst        (rst),
    .clear      (1'b0),
    .write_en   (commit_cm),
    .write_data (writedata),
    .byte_en    (byteenable),
    .value      (cm_sel)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read path and bus answer

  // unmapped reads return zero together with a decode error response
  reg  [31:0] read_mux;

  // the data register already reads zero while blocked, since it is held clear
  always @*
  begin
    read_mux = 32'h0000_0000;
    case (1'b1)
      hit_ref:  read_mux = ref_ctl;
      hit_data: read_mux = dac_data;
      hit_sw:   read_mux = dac_sw;
      hit_cfg:  read_mux = dac_cfg;
      hit_cm:   read_mux = cm_sel;
      default:  read_mux = 32'h0000_0000;
    endcase
  end

  // idle values between answers keep a stale word off the bus
  // waitrequest drops for exactly one cycle per request
  always @(posedge clk)
  begin
    if (rst)
    begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      response    <= `RESP_OKAY;
    end
    else if (state == ST_IDLE && request)
    begin
      waitrequest <= 1'b0;
      readdata    <= read ? read_mux : 32'h0000_0000;
      response    <= hit_any ? `RESP_OKAY : `RESP_DECODE_ERR;
    end
    else
    begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      response    <= `RESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output switch selection

  // effective switch vector, bit order as in the switch register
  reg  [`SW_W-1:0] next_switches;
  wire             override;
  wire             diag_mode;
  wire             powered_down;

  // the three controls that pick the switch source
  assign override     = dac_sw[`SW_OVERRIDE_BIT];
  assign diag_mode    = dac_cfg[`CFG_DIAG_BIT];
  assign powered_down = dac_cfg[`CFG_PD_BIT];

  // power-down beats override, override beats the mode pattern
  always @*
  begin
    next_switches = `SW_ALL_OPEN;
    if (powered_down)
      next_switches = `SW_ALL_OPEN;
    else if (override)
      next_switches = dac_sw[`SW_FIELD_HI:`SW_FIELD_LO];
    else if (diag_mode)
      next_switches = `SW_PATTERN_DIAG;
    else
      next_switches = `SW_PATTERN_NORMAL;
  end

  // registered so the analog switch drivers never see decode glitches
  always @(posedge clk)
  begin
    if (rst)
    begin
      bias_to_potentiostat_switch  <= 1'b0;
      bias_to_filter_pin_switch    <= 1'b0;
      zero_to_lowpower_tia_switch  <= 1'b0;
      zero_to_filter_pin_switch    <= 1'b0;
      zero_to_highspeed_tia_switch <= 1'b0;
    end
    else
    begin
      bias_to_potentiostat_switch  <= next_switches[`SW_BIAS_POT_BIT];
      bias_to_filter_pin_switch    <= next_switches[`SW_BIAS_FILT_BIT];
      zero_to_lowpower_tia_switch  <= next_switches[`SW_ZERO_LPTIA_BIT];
      zero_to_filter_pin_switch    <= next_switches[`SW_ZERO_FILT_BIT];
      zero_to_highspeed_tia_switch <= next_switches[`SW_ZERO_HSTIA_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // codes, references and configuration outputs

  // codes come straight from the data register flops
  assign coarse_code = dac_data[`COARSE_HI:`COARSE_LO];
  assign fine_code   = dac_data[`FINE_HI:`FINE_LO];

  // power controls follow their register bits one cycle later
  // registered so a decode glitch never reaches an analog power switch
  always @(posedge clk)
  begin
    if (rst)
    begin
      ref_buffer_powerdown <= 1'b0;
      bandgap_powerdown    <= 1'b0;
      common_mode_enable   <= 1'b0;
      dac_powerdown        <= 1'b1;
      waveform_source      <= 1'b0;
      zero_mux_select      <= 1'b0;
      bias_mux_select      <= 1'b0;
      reference_select     <= 1'b0;
    end
    else
    begin
      ref_buffer_powerdown <= ref_ctl[`REF_BUF_PD_BIT];
      bandgap_powerdown    <= ref_ctl[`BANDGAP_PD_BIT];
      common_mode_enable   <= cm_sel[`CM_ENABLE_BIT];
      dac_powerdown        <= powered_down;
      waveform_source      <= dac_cfg[`CFG_WAVE_BIT];
      zero_mux_select      <= dac_cfg[`CFG_ZERO_MUX_BIT];
      bias_mux_select      <= dac_cfg[`CFG_BIAS_MUX_BIT];
      reference_select     <= dac_cfg[`CFG_REF_SEL_BIT];
    end
  end

endmodule // lp_dac_switch_and_ref_regs

/* verif/lp_dac_switch_and_ref_regs_chk.sv */
`timescale 1ns/1ps
`include "lp_dac_consts.vh"
////////////////////////////////////////
module lp_dac_chk (
  input wire clk,
  input wire rst,
  input wire [`ADDR_W-1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire [1:0] response,
  input wire waitrequest,
  input wire bias_to_potentiostat_switch,
  input wire bias_to_filter_pin_switch,
  input wire zero_to_lowpower_tia_switch,
  input wire zero_to_filter_pin_switch,
  input wire zero_to_highspeed_tia_switch,
  input wire [5:0] coarse_code,
  input wire [11:0] fine_code,
  input wire ref_buffer_powerdown,
  input wire bandgap_powerdown,
  input wire common_mode_enable,
  input wire dac_powerdown,
  input wire waveform_source,
  input wire zero_mux_select,
  input wire bias_mux_select,
  input wire reference_select
);
  // bus handshake completions and the switch vector, order pot..zero_hs
  wire [4:0] sw = {bias_to_potentiostat_switch, bias_to_filter_pin_switch,
    zero_to_lowpower_tia_switch, zero_to_filter_pin_switch, zero_to_highspeed_tia_switch};
  wire wr_ok = write && !waitrequest;
  wire rd_ok = read && !waitrequest;
  wire data_wr = wr_ok && address == `ADDR_DAC_DATA;
  wire cfg_wr = wr_ok && address == `ADDR_DAC_CFG;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RESET_OUT: assert property ($fell(rst) |-> dac_powerdown && sw == 5'h00
    && !bandgap_powerdown && fine_code == 12'h000 && coarse_code == 6'h00)
    else $error("reset outputs wrong");
  // switches and the power-down copy are registered together, so no lag is allowed
  AST_PD_OPEN: assert property (dac_powerdown |-> sw == 5'h00)
    else $error("switch closed in pd");
  // power copies move one edge after the commit edge, so look two edges on
  AST_REF_BUF: assert property (wr_ok && address == `ADDR_REF_CTL && byteenable[0]
    |-> ##2 ref_buffer_powerdown == $past(writedata[1], 2)) else $error("ref buffer pd");
  AST_BANDGAP: assert property (wr_ok && address == `ADDR_REF_CTL && byteenable[0]
    |-> ##2 bandgap_powerdown == $past(writedata[0], 2)) else $error("bandgap pd");
  AST_CM_EN: assert property (wr_ok && address == `ADDR_CM_SEL && byteenable[0]
    |-> ##2 common_mode_enable == $past(writedata[3], 2)) else $error("cm enable");
  // codes move at a data commit, or one edge after a config commit clears them
  AST_CODE_HOLD: assert property ($changed({coarse_code, fine_code})
    |-> $past(data_wr) || $past(cfg_wr, 2)) else $error("code moved");
  AST_RSVD: assert property (rd_ok |-> !(
    (address == `ADDR_REF_CTL && readdata[31:2] != 0) ||
    (address == `ADDR_DAC_DATA && readdata[31:18] != 0) ||
    (address == `ADDR_DAC_SW && readdata[31:6] != 0) ||
    (address == `ADDR_DAC_CFG && readdata[31:7] != 0) ||
    (address == `ADDR_CM_SEL && readdata[31:4] != 0))) else $error("reserved set");
  AST_OVERRIDE: assert property (rd_ok && address == `ADDR_DAC_SW && readdata[5]
    && !dac_powerdown && !$past(dac_powerdown) |-> sw == readdata[4:0])
    else $error("override");
  AST_MODE: assert property (rd_ok && address == `ADDR_DAC_SW && !readdata[5]
    && !dac_powerdown && !$past(dac_powerdown) |-> sw == 5'h0a || sw == 5'h0b)
    else $error("mode pattern");
endmodule // lp_dac_chk

/* verif/lp_dac_switch_and_ref_regs_tb.sv */
`timescale 1ns/1ps
`include "lp_dac_consts.vh"
////////////////////////////////////////
module lp_dac_switch_and_ref_regs_tb;
  logic clk = 0, rst = 1, rd = 0, wr = 0;
  logic [15:0] adr = 0;
  logic [31:0] wd = 0, q;
  logic [3:0] be = 0;
  wire [31:0] rdat;
  wire [1:0] resp;
  wire [4:0] sw;
  wire [5:0] coarse;
  wire [11:0] fine;
  wire wq, refb, bg, cm, pd, wsrc, zmux, bmux, rsel;
  int mismatches = 0, n_tests = 0, i, k;
  logic [15:0] A [5] = '{16'h2050, 16'h2120, 16'h2124, 16'h2128, 16'h235c};
  logic [31:0] WM [5] = '{32'h3, 32'h3ffff, 32'h3f, 32'h7f, 32'hf};
  logic [31:0] M [6];
  always #12.5 clk = ~clk;
  lp_dac_switch_and_ref_regs dut_u (.clk(clk), .rst(rst), .address(adr), .read(rd),
    .write(wr), .writedata(wd), .byteenable(be), .readdata(rdat), .response(resp),
    .waitrequest(wq), .bias_to_potentiostat_switch(sw[4]), .bias_to_filter_pin_switch(sw[3]),
    .zero_to_lowpower_tia_switch(sw[2]), .zero_to_filter_pin_switch(sw[1]),
    .zero_to_highspeed_tia_switch(sw[0]), .coarse_code(coarse), .fine_code(fine),
    .ref_buffer_powerdown(refb), .bandgap_powerdown(bg), .common_mode_enable(cm),
    .dac_powerdown(pd), .waveform_source(wsrc), .zero_mux_select(zmux),
    .bias_mux_select(bmux), .reference_select(rsel));
  ////////////////////////////////////////
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function int idx(input logic [15:0] a);
    idx = 5;
    for (int j = 0; j < 5; j++)
      if (A[j] == a)
        idx = j;
  endfunction
  // one avalon access; held until waitrequest is sampled low, the watchdog bounds the wait
  task xfer(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] b);
    int x;
    logic [31:0] m;
    x = idx(a);
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    @(posedge clk);
    adr <= a;
    wd <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk);
    end while (wq !== 1'b0);
    q = rdat;
    check("resp", resp, (x < 5) ? 2'h0 : 2'h3);
    rd <= 0;
    wr <= 0;
    // data only takes writes while the enable bit is set, and is erased when it is not
    if (w && x < 5 && (x != 1 || M[3][0]))
      M[x] = (M[x] & ~(m & WM[x])) | (d & m & WM[x]);
    if (!M[3][0])
      M[1] = 0;
  endtask
  task rd_all;
    for (int j = 0; j < 5; j++)
    begin
      xfer(0, A[j], 0, 4'hf);
      check("reg", q, M[j]);
    end
  endtask
  // copies and the switch stage both lag a commit by one edge; three edges leave margin
  task chk_out;
    logic [4:0] e;
    repeat (3) @(posedge clk);
    e = M[3][1] ? 5'h00 : M[2][5] ? M[2][4:0] : M[3][5] ? 5'h0b : 5'h0a;
    check("sw", sw, e);
    check("codes", {coarse, fine}, M[1][17:0]);
    check("ref", {refb, bg}, M[0][1:0]);
    check("cm", cm, M[4][3]);
    check("cfg", {wsrc, zmux, bmux, rsel, pd}, {M[3][6], M[3][4:1]});
  endtask
  task end_of_test;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #200000;
    mismatches++;
    end_of_test;
  end
  initial
  begin
    k = $urandom(23);
    M = '{32'h0, 32'h0, 32'h8, 32'h2, 32'h0, 32'h0};
    repeat (12) @(posedge clk);
    rst <= 0;
    chk_out;
    rd_all;
    // blocked data write, then an unmapped place
    xfer(1, A[1], 32'h0003_ffff, 4'hf);
    xfer(1, 16'h2130, 32'hffff_ffff, 4'hf);
    xfer(0, 16'h2130, 0, 4'hf);
    check("unmapped", q, 32'h0);
    rd_all;
    // powered on, normal then diagnostic pattern
    for (i = 0; i < 2; i++)
    begin
      xfer(1, A[3], 32'h1 | (i << 5), 4'hf);
      chk_out;
      rd_all;
    end
    // each switch alone under override, full-scale codes with reserved bits set
    for (i = 0; i < 5; i++)
    begin
      xfer(1, A[2], 32'hffff_ffe0 | (1 << i), 4'hf);
      chk_out;
      rd_all;
    end
    xfer(1, A[1], 32'hffff_ffff, 4'hf);
    chk_out;
    // random traffic over all places and lanes
    for (i = 0; i < 40; i++)
    begin
      k = $urandom % 6;
      xfer(1, (k < 5) ? A[k] : 16'h2200, $urandom, $urandom);
      chk_out;
      rd_all;
    end
    // clearing the enable erases the codes; then a mid-run reset
    xfer(1, A[3], 32'h0, 4'hf);
    chk_out;
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    M = '{32'h0, 32'h0, 32'h8, 32'h2, 32'h0, 32'h0};
    chk_out;
    rd_all;
    end_of_test;
  end
endmodule // lp_dac_switch_and_ref_regs_tb
bind lp_dac_switch_and_ref_regs lp_dac_chk chk_u (.clk(clk), .rst(rst), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .response(response), .waitrequest(waitrequest),
  .bias_to_potentiostat_switch(bias_to_potentiostat_switch),
  .bias_to_filter_pin_switch(bias_to_filter_pin_switch),
  .zero_to_lowpower_tia_switch(zero_to_lowpower_tia_switch),
  .zero_to_filter_pin_switch(zero_to_filter_pin_switch),
  .zero_to_highspeed_tia_switch(zero_to_highspeed_tia_switch),
  .coarse_code(coarse_code), .fine_code(fine_code),
  .ref_buffer_powerdown(ref_buffer_powerdown), .bandgap_powerdown(bandgap_powerdown),
  .common_mode_enable(common_mode_enable), .dac_powerdown(dac_powerdown),
  .waveform_source(waveform_source), .zero_mux_select(zero_mux_select),
  .bias_mux_select(bias_mux_select), .reference_select(reference_select));
